// *** rtl/sd_adc_ctrl.v ***
// Control and offset-cancel registers of the sigma-delta converter on Wishbone
//
// Local design decisions: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`include "sd_adc_defs.vh"
module sd_adc_ctrl (
  input  wire        CLK_SYS,
  input  wire        SYS_RST,
  input  wire        CE,
  input  wire        WB_CYC_I,
  input  wire        WB_STB_I,
  input  wire        WB_WE_I,
  input  wire [7:0]  WB_ADR_I,
  input  wire [3:0]  WB_SEL_I,
  input  wire [31:0] WB_DAT_I,
  output reg  [31:0] WB_DAT_O,
  output reg         WB_ACK_O,
  output reg  [1:0]  GAIN_SEL,
  output reg         CONV_TIME_SEL,
  output reg         MOD_RUN,
  output wire        STATE_TICK,
  output reg         CONV_ACTIVE,
  output reg         CONV_DONE,
  output reg  [2:0]  CHANNEL,
  output reg  [9:0]  OFFSET_CODE,
  output reg         OFFSET_VALID
);
  reg  [15:0] ctrl_r;
  reg  [9:0]  ofs_r [0:3];
  reg         active_r;
  reg         scan_r;
  reg  [2:0]  chan_r;
  reg  [15:0] ctrl_nxt;
  reg  [15:0] ofs_nxt;
  reg  [31:0] rdata_nxt;
  wire        tick;
  wire        done;
  wire [8:0]  count;
  // Bus decode and per-register write strobes
  wire        req;
  wire        wr;
  wire        hit;
  wire [5:0]  adr;
  wire [1:0]  ofs_idx;
  wire        ctrl_wr;
  wire        ofs_wr;
  wire        run_wr;
  wire [2:0]  chan_req;
  integer     i;

  // Byte-lane merge of a 16-bit register value
  function [15:0] lane_merge;
    input [15:0] old;
    input [15:0] wdat;
    input [1:0]  sel;
    begin
      lane_merge[7:0]  = sel[0] ? wdat[7:0] : old[7:0];
      lane_merge[15:8] = sel[1] ? wdat[15:8] : old[15:8];
    end
  endfunction

  // Offset slot of a word address: 04h..10h give 0..3, always in range
  function [1:0] ofs_slot;
    input [5:0] a;
    reg   [5:0] rel;
    begin
      rel      = a - `ADR_OFS0;
      ofs_slot = rel[3:2];
    end
  endfunction

  // True for the four offset-cancel register addresses
  function is_ofs;
    input [5:0] a;
    begin
      is_ofs = (a >= `ADR_OFS0) && (a <= `ADR_OFS3);
    end
  endfunction

  // Access is taken on the first cycle of a request; ack follows one edge later
  assign req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  assign wr  = req & WB_WE_I;

  // Word address inside the 64-byte window; anything above it is unmapped
  assign hit     = (WB_ADR_I[7:6] == 2'b00);
  assign adr     = {WB_ADR_I[5:2], 2'b00};
  assign ofs_idx = ofs_slot(adr);

  // Write strobes per register; settings frozen while a conversion runs
  assign ctrl_wr = wr & hit & ~active_r & (adr == `ADR_CTRL); // R14
  assign ofs_wr  = wr & hit & ~active_r & is_ofs(adr); // R14
  assign run_wr  = wr & hit & (adr == `ADR_RUN) & WB_SEL_I[0];

  // Channel field of a run write, clamped to the six inputs
  assign chan_req = (WB_DAT_I[`RUN_CH_HI:`RUN_CH_LO] > 3'h5) ? 3'h5 : WB_DAT_I[`RUN_CH_HI:`RUN_CH_LO];

  // Writable control bits only; read-only reserved bits stay zero
  always @*
  begin
    ctrl_nxt = lane_merge(ctrl_r, WB_DAT_I[15:0], WB_SEL_I[1:0]) & `CTRL_RW_MASK; // R06
    ofs_nxt  = lane_merge({6'h00, ofs_r[ofs_idx]}, WB_DAT_I[15:0], WB_SEL_I[1:0]); // R08
  end

  // Read data mux; unmapped addresses read zero
  always @*
  begin
    rdata_nxt = 32'h00000000;
    if (hit)
    begin
      case (adr)
        `ADR_CTRL:   rdata_nxt = {16'h0000, ctrl_r & `CTRL_RW_MASK}; // R06
        `ADR_OFS0:   rdata_nxt = {22'h000000, ofs_r[0]}; // R08
        `ADR_OFS1:   rdata_nxt = {22'h000000, ofs_r[1]};
        `ADR_OFS2:   rdata_nxt = {22'h000000, ofs_r[2]};
        `ADR_OFS3:   rdata_nxt = {22'h000000, ofs_r[3]};
        `ADR_RUN:    rdata_nxt = {25'h0000000, chan_r, 2'b00, scan_r, active_r};
        `ADR_STATUS: rdata_nxt = {23'h000000, count};
        default:     rdata_nxt = 32'h00000000;
      endcase
    end
  end

  // Wishbone answer: one-cycle ack with registered read data
  always @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
    end
    else if (CE)
    begin
      WB_ACK_O <= req;
      if (req && !WB_WE_I)
        WB_DAT_O <= rdata_nxt;
    end
  end

  // Register file and conversion run state
  always @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      ctrl_r   <= `CTRL_RESET; // R03
      for (i = 0; i < 4; i = i + 1)
        ofs_r[i] <= `OFS_RESET;
      active_r <= 1'b0;
      scan_r   <= 1'b0;
      chan_r   <= 3'h0;
    end
    else if (CE)
    begin
      // Settings frozen while a conversion runs
      if (ctrl_wr)
        ctrl_r <= ctrl_nxt; // R14
      if (ofs_wr)
        ofs_r[ofs_idx] <= ofs_nxt[9:0]; // R14
      // Channel and scan fields also frozen during a conversion
      if (run_wr && !active_r)
      begin
        scan_r <= WB_DAT_I[`RUN_SCAN_BIT];
        chan_r <= chan_req;
      end
      // Software start or stop; a write of 1 wins over end-of-conversion clear
      if (run_wr)
        active_r <= WB_DAT_I[`RUN_ACT_BIT]; // R12
      else if (done && !scan_r)
        active_r <= 1'b0; // R12
    end
  end

  // Analog-side outputs, all registered
  always @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      GAIN_SEL      <= 2'b11;
      CONV_TIME_SEL <= 1'b0;
      MOD_RUN       <= 1'b0;
      CONV_ACTIVE   <= 1'b0;
      CONV_DONE     <= 1'b0;
      CHANNEL       <= 3'h0;
      OFFSET_CODE   <= `DAC_MID;
      OFFSET_VALID  <= 1'b0;
    end
    else if (CE)
    begin
      GAIN_SEL      <= ctrl_r[`CTRL_GAIN_HI:`CTRL_GAIN_LO]; // R03
      CONV_TIME_SEL <= ctrl_r[`CTRL_TSEL_BIT];
      MOD_RUN       <= ctrl_r[`CTRL_MRUN_BIT]; // R04
      CONV_ACTIVE   <= active_r;
      CONV_DONE     <= done;
      CHANNEL       <= chan_r;
      // Single-ended channels get their own code; others idle at mid scale
      if (active_r && chan_r < 3'h4)
      begin
        OFFSET_CODE  <= ofs_r[chan_r[1:0]]; // R13 R11
        OFFSET_VALID <= 1'b1;
      end
      else
      begin
        OFFSET_CODE  <= `DAC_MID;
        OFFSET_VALID <= 1'b0;
      end
    end
  end

  // Eighth-rate states, gated by the modulator run bit
  state_counter #(
    .DIV    (`CLK_DIV),
    .STATES (`CONV_STATES)
  ) u_states (
    .clk    (CLK_SYS),
    .rst    (SYS_RST),
    .ce     (CE),
    .run    (ctrl_r[`CTRL_MRUN_BIT]),
    .active (active_r),
    .tick   (tick),
    .done   (done),
    .count  (count)
  );

  // Tick comes straight from the divider flop
  assign STATE_TICK = tick;
endmodule // sd_adc_ctrl

// *** rtl/sd_adc_defs.vh ***
// Constants for the sigma-delta converter control and offset-cancel registers
// Functional notes
// R01: Software changes the control register only while conversion_active is clear.
// R02: Conversion time select 0 gives 286 eighth-rate states; never write 1.
// R03: Gain field bits 13:12 select x1, x2, x4, x8; resets to 11.
// R04: modulator_run bit 7 stops or runs modulator and eighth-rate clock; resets 0.
// R05: Software writes 1 to control bit 3 and 0 to bits 10:8.
// R06: Control bits 14, 11, 6:4 and 2:0 always read zero.
// R07: Software changes offset registers only while conversion_active is clear.
// R08: Offset registers hold ten bits; upper six read zero, ignore writes.
// R09: Gain 00 or 01 needs offset 200h; gain 11 allows any code.
// R10: Gain 10 needs even offset codes up to 3FEh.
// R11: Offset DAC level is code over 1024 times reference span.
// R12: conversion_active starts and stops conversion; single mode clears it at end.
// R13: During conversion on channel 0 to 3 its offset code drives the DAC.
// R14: Control and offset writes are ignored while conversion_active is set.
`ifndef SD_ADC_DEFS_VH
`define SD_ADC_DEFS_VH
`define ADR_CTRL        6'h00
`define ADR_OFS0        6'h04
`define ADR_OFS1        6'h08
`define ADR_OFS2        6'h0c
`define ADR_OFS3        6'h10
`define ADR_RUN         6'h14
`define ADR_STATUS      6'h18
`define CTRL_RESET      16'h3008
`define CTRL_RW_MASK    16'hb788
`define CTRL_TSEL_BIT   15
`define CTRL_GAIN_HI    13
`define CTRL_GAIN_LO    12
`define CTRL_MRUN_BIT   7
`define OFS_RESET       10'h200
`define OFS_WIDTH       10
`define DAC_MID         10'h200
`define RUN_ACT_BIT     0
`define RUN_SCAN_BIT    1
`define RUN_CH_HI       6
`define RUN_CH_LO       4
`define CLK_DIV         8
`define CONV_STATES     286
`endif

// *** rtl/state_counter.v ***
// Eighth-rate state tick generator and conversion state counter
`timescale 1ns/1ps
module state_counter #(
  parameter DIV    = 8,
  parameter STATES = 286
) (
  input  wire       clk,
  input  wire       rst,
  input  wire       ce,
  input  wire       run,
  input  wire       active,
  output reg        tick,
  output reg        done,
  output reg  [8:0] count
);
  reg [3:0] div_r;

  // Divider stops with run low, so the eighth-rate clock is gated off
  always @(posedge clk)
  begin
    if (rst)
    begin
      div_r <= 4'h0;
      tick  <= 1'b0;
      done  <= 1'b0;
      count <= 9'h000;
    end
    else if (ce)
    begin
      tick <= 1'b0;
      done <= 1'b0;
      if (!run)
        div_r <= 4'h0; // R04
      else if (div_r == DIV[3:0] - 4'h1)
      begin
        div_r <= 4'h0;
        tick  <= 1'b1;
      end
      else
        div_r <= div_r + 4'h1;
      // Count states of a conversion; end pulse on the last state
      if (!active)
        count <= 9'h000;
      else if (tick)
      begin
        if (count == STATES[8:0] - 9'h001)
        begin
          count <= 9'h000;
          done  <= 1'b1; // R02
        end
        else
          count <= count + 9'h001;
      end
    end
  end
endmodule // state_counter

// *** testbench/sd_adc_ctrl_chk.sv ***
// Port checks for the converter register block
`timescale 1ns/1ps
module sd_adc_ctrl_chk (
  input wire       CLK_SYS,
  input wire       SYS_RST,
  input wire       CE,
  input wire       WB_CYC_I,
  input wire       WB_STB_I,
  input wire       WB_ACK_O,
  input wire [1:0] GAIN_SEL,
  input wire       MOD_RUN,
  input wire       STATE_TICK,
  input wire       CONV_ACTIVE,
  input wire       CONV_DONE,
  input wire [2:0] CHANNEL,
  input wire [9:0] OFFSET_CODE,
  input wire       OFFSET_VALID
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  // Bus answer one cycle after a taken request
  ack_next_a: assert property (CE && WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O) else $error("ack late");
  ack_once_a: assert property (CE && WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
  reset_vals_a: assert property ($fell(SYS_RST) |-> GAIN_SEL == 2'b11 && !MOD_RUN && !CONV_ACTIVE)
    else $error("bad reset value");
  // Eighth-rate tick
  tick_stop_a: assert property (!MOD_RUN && !$past(MOD_RUN) |-> !STATE_TICK) else $error("tick while stopped");
  tick_gap_a: assert property (STATE_TICK |=> (!STATE_TICK) [*7]) else $error("tick spacing");
  // Settings frozen during conversion
  ctrl_hold_a: assert property (CONV_ACTIVE && $past(CONV_ACTIVE) |-> $stable(GAIN_SEL) && $stable(MOD_RUN))
    else $error("control changed");
  offs_hold_a: assert property (OFFSET_VALID && $past(OFFSET_VALID) |-> $stable(OFFSET_CODE))
    else $error("offset changed");
  // Offset DAC source
  offs_idle_a: assert property (!OFFSET_VALID |-> OFFSET_CODE == 10'h200) else $error("idle code");
  offs_src_a: assert property (OFFSET_VALID |-> CONV_ACTIVE && CHANNEL < 3'h4) else $error("code outside conversion");
  // End-of-conversion pulse
  done_pulse_a: assert property (CE && CONV_DONE |=> !CONV_DONE) else $error("done too long");
endmodule // sd_adc_ctrl_chk
bind sd_adc_ctrl sd_adc_ctrl_chk chk (.*);

// *** testbench/analog_side.sv ***
// Model of modulator and offset DAC
`timescale 1ns/1ps
module analog_side (
  input  wire       CLK_SYS,
  input  wire       MOD_RUN,
  input  wire       STATE_TICK,
  input  wire [9:0] OFFSET_CODE,
  input  wire       OFFSET_VALID,
  output integer    ticks,
  output integer    level_mv
);
  initial ticks = 0;
  // Modulator samples once per state
  always @(posedge CLK_SYS)
    if (MOD_RUN && STATE_TICK) ticks <= ticks + 1;
  // Cancel level over a 3 V span
  always @*
    level_mv = OFFSET_VALID ? OFFSET_CODE * 3000 / 1024 : 1500;
endmodule // analog_side

// *** testbench/sigma_delta_adc_control_offset_bench.sv ***
// Self-checking bench for the converter register block
`timescale 1ns/1ps
module sigma_delta_adc_control_offset_bench;
  reg          clk = 0, rst = 1, ce = 1, cyc = 0, stb = 0, we = 0;
  reg  [7:0]   adr = 8'h00;
  reg  [3:0]   sel = 4'h0;
  reg  [31:0]  dat = 32'h0;
  wire [31:0]  rdat;
  wire         ack, mrun, tick, act, done, tsel, vld;
  wire [1:0]   gain;
  wire [2:0]   chan;
  wire [9:0]   code;
  integer      ticks, lvl, bad_count = 0, num_checks = 0, n, t0, i;
  reg  [9:0]   ofs [0:3];
  logic [15:0] q [$];
  always #25 clk = ~clk;
  sd_adc_ctrl uut (.CLK_SYS(clk), .SYS_RST(rst), .CE(ce), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .GAIN_SEL(gain),
    .CONV_TIME_SEL(tsel), .MOD_RUN(mrun), .STATE_TICK(tick), .CONV_ACTIVE(act), .CONV_DONE(done),
    .CHANNEL(chan), .OFFSET_CODE(code), .OFFSET_VALID(vld));
  analog_side far (.CLK_SYS(clk), .MOD_RUN(mrun), .STATE_TICK(tick), .OFFSET_CODE(code),
    .OFFSET_VALID(vld), .ticks(ticks), .level_mv(lvl));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One classic bus cycle; reads leave their expectation
  task wb(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [15:0] e);
    integer k;
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    sel <= 4'h3;
    dat <= {16'h0000, d};
    if (!w) q.push_back(e);
    k = 0;
    do @(posedge clk); while (ack !== 1'b1 && ++k < 50);
    if (k >= 50) bad_count++;
    cyc <= 0;
    stb <= 0;
  endtask
  // Read data against the oldest note
  always @(posedge clk)
    if (ack === 1'b1 && !we && q.size() > 0) chk(rdat, {16'h0000, q.pop_front()});
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    #2000000;
    bad_count++;
    wrap_up;
  end
  initial
  begin
    n = $urandom(35);
    repeat (5) @(posedge clk);
    rst <= 0;
    // Reset values and two unmapped places
    wb(0, 8'h00, 0, 16'h3008);
    for (i = 0; i < 4; i++) wb(0, 8'h04 + 4 * i, 0, 16'h0200);
    wb(0, 8'h3c, 0, 16'h0000);
    wb(0, 8'h40, 0, 16'h0000);
    wb(0, 8'h14, 0, 16'h0000);
    wb(0, 8'h18, 0, 16'h0000);
    $display("test 1 done");
    // Read-only bits, every gain code
    wb(1, 8'h00, 16'h787f, 0);
    wb(0, 8'h00, 0, 16'h3008);
    wb(1, 8'h40, 16'h0088, 0);
    wb(0, 8'h00, 0, 16'h3008);
    for (i = 0; i < 4; i++)
    begin
      wb(1, 8'h00, 16'h0088 | (i << 12), 0);
      wb(0, 8'h00, 0, 16'h0088 | (i << 12));
      chk({gain, mrun, tsel}, {i[1:0], 2'b10});
    end
    $display("test 2 done");
    // Random offsets, upper bits dropped
    for (i = 0; i < 4; i++)
    begin
      ofs[i] = $urandom;
      wb(1, 8'h04 + 4 * i, {6'h3f, ofs[i]}, 0);
      wb(0, 8'h04 + 4 * i, 0, {6'h00, ofs[i]});
    end
    $display("test 3 done");
    // Conversion on channels 0 to 4, writes refused meanwhile
    for (i = 0; i < 5; i++)
    begin
      t0 = ticks;
      wb(1, 8'h14, 16'h0001 | (i << 4), 0);
      wb(1, 8'h00, 16'h0008, 0);
      wb(1, 8'h04 + 4 * (i % 4), 16'h0000, 0);
      chk({vld, code}, i < 4 ? {1'b1, ofs[i % 4]} : 11'h200);
      chk({gain, mrun}, 3'b111);
      chk(chan, i);
      chk(lvl, i < 4 ? ofs[i % 4] * 3000 / 1024 : 1500);
      n = 0;
      while (done !== 1'b1 && n < 3000)
      begin
        @(posedge clk);
        n++;
      end
      chk(n < 3000, 1);
      chk(ticks - t0 >= 286 && ticks - t0 <= 288, 1);
      repeat (3) @(posedge clk);
      chk(act, 0);
      wb(0, 8'h04 + 4 * (i % 4), 0, ofs[i % 4]);
    end
    $display("test 4 done");
    // Channel clamp, scan mode keeps converting until software stops it
    wb(1, 8'h14, 16'h0072, 0);
    wb(0, 8'h14, 0, 16'h0052);
    wb(1, 8'h14, 16'h0003, 0);
    n = 0;
    while (done !== 1'b1 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    chk(n < 3000, 1);
    repeat (3) @(posedge clk);
    chk({act, vld, code}, {2'b11, ofs[0]});
    wb(1, 8'h14, 16'h0000, 0);
    repeat (3) @(posedge clk);
    chk({act, vld}, 2'b00);
    wb(0, 8'h14, 0, 16'h0002);
    $display("test 5 done");
    // Stopped modulator gives no states
    wb(1, 8'h00, 16'h3008, 0);
    repeat (3) @(posedge clk);
    t0 = ticks;
    repeat (40) @(posedge clk);
    chk(ticks - t0, 0);
    $display("test 6 done");
    // Clock enable low holds off the answer and the write
    ce <= 0;
    fork
      wb(1, 8'h00, 16'h3088, 0);
      begin
        repeat (9) @(posedge clk);
        chk({ack, mrun}, 2'b00);
        ce <= 1;
      end
    join
    repeat (2) @(posedge clk);
    chk({gain, mrun}, 3'b111);
    $display("test 7 done");
    wrap_up;
  end
endmodule // sigma_delta_adc_control_offset_bench
